// [include/dsj_pkg.sv]
// constants, types and register map of the displacement output stage
package dsj_pkg;
  // =========================================================
  // widths
  localparam int DW = 16;  // measurement and setting width
  localparam int XW = 20;  // internal signed arithmetic width
  localparam int AW = 8;   // bus address width
  localparam int HD = 32;  // sample history depth
  localparam int NK = 7;   // settings per switching channel

  // =========================================================
  // register byte offsets
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_CMD  = 8'h04;
  localparam logic [AW-1:0] A_STAT = 8'h08;
  localparam logic [AW-1:0] A_ALO  = 8'h0c;
  localparam logic [AW-1:0] A_AHI  = 8'h10;
  localparam logic [AW-1:0] A_SPAN = 8'h14;
  localparam logic [AW-1:0] A_MREL = 8'h18;
  localparam logic [AW-1:0] A_EDGE = 8'h1c;
  localparam logic [1:0]    A_CHB  = 2'h1;  // addr[7:6] of channel blocks

  // channel setting index, addr[4:2] inside a block
  localparam int K_T1   = 0;
  localparam int K_T2   = 1;
  localparam int K_HYS  = 2;
  localparam int K_TOL  = 3;
  localparam int K_EMIN = 4;
  localparam int K_EMAX = 5;
  localparam int K_EOPT = 6;

  // =========================================================
  // field positions
  localparam int F_M1   = 0;   // mode of channel one, 3 bits
  localparam int F_M2   = 4;   // mode of second output, 3 bits
  localparam int F_POL1 = 8;   // far-on polarity, channel one
  localparam int F_POL2 = 9;   // far-on polarity, second output
  localparam int F_MDIR = 12;  // measurement direction reversed
  localparam int C_TLO  = 0;   // teach low endpoint
  localparam int C_THI  = 1;   // teach high endpoint
  localparam int C_OFS  = 2;   // offset operation
  localparam int C_REL  = 3;   // offset release
  localparam int F_COFS = 0;   // cycle offset, 5 bits
  localparam int F_EDIR = 8;   // edge direction, 2 bits
  localparam int F_HOLD = 12;  // edge hold enable

  localparam logic [1:0] DIR_NEG  = 2'h1;
  localparam logic [1:0] DIR_BOTH = 2'h2;

  // =========================================================
  // analog levels: current in uA, voltage in mV
  localparam logic [15:0] I_LO = 16'h0fa0;  // 4 mA
  localparam logic [15:0] I_HI = 16'h4e20;  // 20 mA
  localparam logic [15:0] I_OR = 16'h5208;  // 21 mA
  localparam logic [15:0] V_LO = 16'h0000;  // 0 V
  localparam logic [15:0] V_HI = 16'h2710;  // 10 V
  localparam logic [15:0] V_OR = 16'h2af8;  // 11 V
  localparam logic [19:0] SPAN_DIV = 20'h0000a;  // span tenth

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] ALO_RST  = 16'h0000;
  localparam logic [15:0] AHI_RST  = 16'h1388;
  localparam logic [15:0] SPAN_RST = 16'h1388;
  localparam logic signed [XW-1:0] XMAX = 20'sh3ffff;

  typedef enum logic [2:0] {
    M_ONE, M_ZONE, M_TOL, M_EDGE, M_AI, M_AV, M_INV
  } dsj_mode_t;
endpackage

// [hdl/dsj_top.sv]
// displacement output stage: switching judgments and analog scale
module dsj_top
  import dsj_pkg::*;
(
  input  wire logic          CLK_I,
  input  wire logic          NRST_I,
  input  wire logic          CE_I,
  input  wire logic [15:0]   MEAS_I,
  input  wire logic          MEAS_VLD_I,
  input  wire logic          MEAS_OOR_I,
  input  wire logic [AW-1:0] S_AXI_AWADDR_I,
  input  wire logic          S_AXI_AWVALID_I,
  output logic               S_AXI_AWREADY_O,
  input  wire logic [31:0]   S_AXI_WDATA_I,
  input  wire logic [3:0]    S_AXI_WSTRB_I,
  input  wire logic          S_AXI_WVALID_I,
  output logic               S_AXI_WREADY_O,
  output logic [1:0]         S_AXI_BRESP_O,
  output logic               S_AXI_BVALID_O,
  input  wire logic          S_AXI_BREADY_I,
  input  wire logic [AW-1:0] S_AXI_ARADDR_I,
  input  wire logic          S_AXI_ARVALID_I,
  output logic               S_AXI_ARREADY_O,
  output logic [31:0]        S_AXI_RDATA_O,
  output logic [1:0]         S_AXI_RRESP_O,
  output logic               S_AXI_RVALID_O,
  input  wire logic          S_AXI_RREADY_I,
  output logic               SWITCH_OUTPUT_ONE_O,
  output logic               SECOND_OUTPUT_OR_ANALOG_O,
  output logic [15:0]        AO_CODE_O,
  output logic [15:0]        MEAS_REL_O
);
  // =========================================================
  // helpers
  function automatic logic signed [XW-1:0] sx(input logic [15:0] v);
    return XW'($signed(v));
  endfunction

  function automatic logic win(input logic signed [XW-1:0] x,
                               input logic signed [XW-1:0] lo,
                               input logic signed [XW-1:0] hi);
    return (x >= lo) && (x <= hi);
  endfunction

  // endpoint pair wide enough against sensor span
  function automatic logic span_ok(input logic [15:0] a,
                                   input logic [15:0] b,
                                   input logic [15:0] s);
    logic signed [XW-1:0] d;
    d = sx(a) - sx(b);
    if (d < 0) d = -d;
    return (20'(d) * SPAN_DIV) >= {4'h0, s};
  endfunction

  // =========================================================
  // state
  logic [31:0]       ctrl_q;
  logic [15:0]       alo_q, ahi_q, span_q, ofs_q, raw_q;
  logic [15:0]       chr_q [2][NK];
  logic [15:0]       hist_q [HD];
  logic [15:0]       eh_q [2];
  logic [1:0]        on_q, ein_q;
  logic              oor_q, ofs_on_q, rc_q, achg_q, rej_q;
  logic              aw_rdy_q, ar_rdy_q;
  logic [31:0]       wold, rdat;
  dsj_mode_t         md [2];

  assign S_AXI_AWREADY_O = aw_rdy_q;
  assign S_AXI_WREADY_O  = aw_rdy_q;
  assign S_AXI_ARREADY_O = ar_rdy_q;
  assign S_AXI_BRESP_O   = 2'h0;
  assign S_AXI_RRESP_O   = 2'h0;

  // =========================================================
  // register read decode, shared by reads and byte merges
  function automatic logic [31:0] rdv(input logic [AW-1:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      A_CTRL: r = ctrl_q;
      A_STAT: r = {27'h0, rc_q, ofs_on_q, rej_q,
                   SECOND_OUTPUT_OR_ANALOG_O, SWITCH_OUTPUT_ONE_O};
      A_ALO:  r = {16'h0, alo_q};
      A_AHI:  r = {16'h0, ahi_q};
      A_SPAN: r = {16'h0, span_q};
      A_MREL: r = {16'h0, MEAS_REL_O};
      A_EDGE: r = {eh_q[1], eh_q[0]};
      default: begin
        if (a[7:6] == A_CHB && a[4:2] < 3'(NK)) begin
          r = {16'h0, chr_q[a[5]][a[4:2]]};
        end
      end
    endcase
    return r;
  endfunction

  always_comb begin
    wold = rdv(S_AXI_AWADDR_I);
    rdat = rdv(S_AXI_ARADDR_I);
  end

  // byte-lane merge of write data
  logic [31:0] wnew;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wnew[8*i +: 8] = S_AXI_WSTRB_I[i] ? S_AXI_WDATA_I[8*i +: 8]
                                         : wold[8*i +: 8];
    end
  end

  // =========================================================
  // write decode and commands
  wire [AW-1:0] wa   = S_AXI_AWADDR_I;
  wire wr_go  = CE_I & aw_rdy_q;
  wire wr_ch  = wr_go & (wa[7:6] == A_CHB) & (wa[4:2] < 3'(NK));
  wire [3:0] cmd = (wr_go && wa == A_CMD) ? wnew[3:0] : 4'h0;
  wire [15:0] mrel = raw_q - (ofs_on_q ? ofs_q : 16'h0);
  // low and high endpoint candidates from teach or entry
  wire lo_req = cmd[C_TLO] | (wr_go & (wa == A_ALO));
  wire hi_req = cmd[C_THI] | (wr_go & (wa == A_AHI));
  wire [15:0] lo_new = cmd[C_TLO] ? mrel : wnew[15:0];
  wire [15:0] hi_new = cmd[C_THI] ? mrel : wnew[15:0];
  wire lo_ok = span_ok(lo_new, ahi_q, span_q);
  wire hi_ok = span_ok(alo_q, hi_new, span_q);

  // =========================================================
  // bus handshakes: address and data taken together
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_rdy_q       <= 1'b0;
      ar_rdy_q       <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0;
    end else if (CE_I) begin
      aw_rdy_q <= S_AXI_AWVALID_I & S_AXI_WVALID_I & ~aw_rdy_q
                  & ~S_AXI_BVALID_O;
      ar_rdy_q <= S_AXI_ARVALID_I & ~ar_rdy_q & ~S_AXI_RVALID_O;
      if (aw_rdy_q) S_AXI_BVALID_O <= 1'b1;
      else if (S_AXI_BREADY_I) S_AXI_BVALID_O <= 1'b0;
      if (ar_rdy_q) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O  <= rdat;
      end else if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // =========================================================
  // settings, endpoints and offset
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_q   <= CTRL_RST;
      alo_q    <= ALO_RST;
      ahi_q    <= AHI_RST;
      span_q   <= SPAN_RST;
      ofs_q    <= 16'h0;
      ofs_on_q <= 1'b0;
      rc_q     <= 1'b0;
      achg_q   <= 1'b0;
      rej_q    <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        for (int k = 0; k < NK; k++) chr_q[c][k] <= 16'h0;
      end
    end else if (CE_I) begin
      if (wr_go && wa == A_CTRL) ctrl_q <= wnew;
      if (wr_go && wa == A_SPAN) span_q <= wnew[15:0];
      if (wr_ch) chr_q[wa[5]][wa[4:2]] <= wnew[15:0];
      if (lo_req && lo_ok) alo_q <= lo_new;
      if (hi_req && hi_ok) ahi_q <= hi_new;
      if (lo_req | hi_req) begin
        rej_q <= lo_req ? ~lo_ok : ~hi_ok;
      end
      if ((lo_req & lo_ok) | (hi_req & hi_ok)) achg_q <= 1'b1;
      if (cmd[C_OFS]) begin
        ofs_q    <= raw_q;
        ofs_on_q <= 1'b1;
        rc_q     <= achg_q;
        // an endpoint change in the same write stays pending
        achg_q   <= (lo_req & lo_ok) | (hi_req & hi_ok);
      end else if (cmd[C_REL]) begin
        ofs_on_q <= 1'b0;
        rc_q     <= 1'b0;
      end
    end
  end

  // =========================================================
  // measurement: direction, offset and sample history
  wire signed [XW-1:0] mx = ctrl_q[F_MDIR] ? -sx(MEAS_I) : sx(MEAS_I);
  wire signed [XW-1:0] rel = mx - (ofs_on_q ? sx(ofs_q) : '0);
  wire take = CE_I & MEAS_VLD_I;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      raw_q <= 16'h0;
      oor_q <= 1'b0;
      for (int i = 0; i < HD; i++) hist_q[i] <= 16'h0;
    end else if (take) begin
      raw_q     <= mx[15:0];
      oor_q     <= MEAS_OOR_I;
      hist_q[0] <= mx[15:0];
      for (int i = 1; i < HD; i++) hist_q[i] <= hist_q[i-1];
    end
  end

  // =========================================================
  // assertion clock and reset for the whole module
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  // =========================================================
  // switching channels, both with the same logic
  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire [15:0] eo = chr_q[c][K_EOPT];
    wire [4:0]  ci = (eo[4:0] == 5'h0) ? 5'h0 : eo[4:0] - 5'h1;
    wire signed [XW-1:0] dd = mx - sx(hist_q[ci]);
    wire [1:0] ed = eo[F_EDIR +: 2];
    wire signed [XW-1:0] e = (ed == DIR_NEG || (ed == DIR_BOTH && dd < 0))
                             ? -dd : dd;
    wire signed [XW-1:0] t1 = sx(chr_q[c][K_T1]);
    wire signed [XW-1:0] t2 = sx(chr_q[c][K_T2]);
    wire signed [XW-1:0] tl = {4'h0, chr_q[c][K_TOL]};
    wire signed [XW-1:0] hy = {4'h0, chr_q[c][K_HYS]};
    logic signed [XW-1:0] x, lo, hi;
    logic sw;

    assign md[c] = dsj_mode_t'(ctrl_q[(c == 0 ? F_M1 : F_M2) +: 3]);

    // judgment window per mode
    always_comb begin
      x  = rel;
      lo = t1;
      hi = XMAX;
      sw = 1'b1;
      case (md[c])
        M_ONE: ;
        M_ZONE: begin
          lo = (t1 < t2) ? t1 : t2;
          hi = (t1 < t2) ? t2 : t1;
        end
        M_TOL: begin
          lo = t1 - tl;
          hi = t1 + tl;
        end
        M_EDGE: begin
          x  = e;
          lo = sx(chr_q[c][K_EMIN]);
          hi = sx(chr_q[c][K_EMAX]);
        end
        default: sw = 1'b0;
      endcase
    end

    wire in_on = win(x, lo, hi);
    wire in_hy = win(x, lo - hy, hi + hy);
    wire ent   = (md[c] == M_EDGE) & in_on & ~ein_q[c];

    // on state and edge hold, updated per sample
    always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        on_q[c]  <= 1'b0;
        ein_q[c] <= 1'b0;
        eh_q[c]  <= 16'h0;
      end else if (take) begin
        on_q[c]  <= sw & (on_q[c] ? in_hy : in_on);
        ein_q[c] <= in_on;
        if (!eo[F_HOLD] || ent) eh_q[c] <= e[15:0];
      end
    end

    // hysteresis keeps the output on inside the band
    property p_hold_on;
      take && md[c] == M_ONE && on_q[c] && x >= t1 - hy |=> on_q[c];
    endproperty
    a_hold_on: assert property (p_hold_on)
      else $error("output dropped inside hysteresis");

    property p_zone_off;
      take && md[c] == M_ZONE && !in_hy |=> !on_q[c];
    endproperty
    a_zone_off: assert property (p_zone_off)
      else $error("zone output on outside band");

    property p_tol_on;
      take && md[c] == M_TOL && win(rel, t1 - tl, t1 + tl) |=> on_q[c];
    endproperty
    a_tol_on: assert property (p_tol_on)
      else $error("tolerance window not on");

    property p_edge_hold;
      take && ent && eo[F_HOLD] ##1 !take [*2]
        |-> eh_q[c] == $past(e[15:0], 2);
    endproperty
    a_edge_hold: assert property (p_edge_hold)
      else $error("edge hold did not latch entry value");
  end

  // =========================================================
  // analog scale, optionally recentred on the offset point
  wire is_i = md[1] == M_AI;
  wire is_v = md[1] == M_AV;
  wire signed [XW-1:0] ax  = sx(mrel);
  wire signed [XW-1:0] spa = sx(ahi_q) - sx(alo_q);
  wire signed [XW-1:0] elo = rc_q ? -(spa >>> 1) : sx(alo_q);
  wire signed [XW-1:0] ehi = rc_q ? spa - (spa >>> 1) : sx(ahi_q);
  wire signed [XW-1:0] den = ehi - elo;
  wire [15:0] l_lo = is_i ? I_LO : V_LO;
  wire [15:0] l_or = is_i ? I_OR : V_OR;
  wire signed [XW-1:0] lsp = sx(is_i ? I_HI - I_LO : V_HI - V_LO);
  wire signed [39:0] num = 40'(ax - elo) * 40'(lsp);
  wire signed [39:0] quo = (den == 0) ? 40'sh0 : num / 40'(den);
  wire in_sp = (den != 0) &&
               win(ax, (elo < ehi) ? elo : ehi, (elo < ehi) ? ehi : elo);
  wire [15:0] ao_d = !(is_i | is_v) ? 16'h0
                   : (oor_q | ~in_sp) ? l_or
                   : l_lo + quo[15:0];

  // =========================================================
  // output flops
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SWITCH_OUTPUT_ONE_O       <= 1'b0;
      SECOND_OUTPUT_OR_ANALOG_O <= 1'b0;
      AO_CODE_O                 <= 16'h0;
      MEAS_REL_O                <= 16'h0;
    end else if (CE_I) begin
      SWITCH_OUTPUT_ONE_O <= on_q[0] ^ ctrl_q[F_POL1];
      SECOND_OUTPUT_OR_ANALOG_O <=
        (md[1] == M_INV) ? ~(on_q[0] ^ ctrl_q[F_POL1])
                         : on_q[1] ^ ctrl_q[F_POL2];
      AO_CODE_O  <= ao_d;
      MEAS_REL_O <= mrel;
    end
  end

  // =========================================================
  // checks on the analog path and second output

  property p_inv;
    CE_I && md[1] == M_INV |=> SECOND_OUTPUT_OR_ANALOG_O
                               != SWITCH_OUTPUT_ONE_O;
  endproperty
  a_inv: assert property (p_inv)
    else $error("inverted output equals first output");

  property p_reject;
    lo_req && !lo_ok |=> rej_q && alo_q == $past(alo_q);
  endproperty
  a_reject: assert property (p_reject)
    else $error("narrow endpoint pair accepted");

  property p_teach;
    cmd[C_TLO] && lo_ok |=> alo_q == $past(mrel);
  endproperty
  a_teach: assert property (p_teach)
    else $error("teach did not copy measured value");

  property p_ma_oor;
    CE_I && is_i && oor_q |=> AO_CODE_O == I_OR;
  endproperty
  a_ma_oor: assert property (p_ma_oor)
    else $error("current scale not at out-of-range level");

  property p_v_oor;
    CE_I && is_v && oor_q |=> AO_CODE_O == V_OR;
  endproperty
  a_v_oor: assert property (p_v_oor)
    else $error("voltage scale not at out-of-range level");

  property p_release;
    cmd[C_REL] && !cmd[C_OFS] |=> !rc_q && !ofs_on_q;
  endproperty
  a_release: assert property (p_release)
    else $error("offset release kept recentring");

  c_teach_ok: cover property (cmd[C_THI] && hi_ok);
  c_recentre: cover property (cmd[C_OFS] && achg_q);
  c_edge_ent: cover property (take && g_ch[0].ent);
endmodule

// [tb/dsj_ctrl_model.sv]
// controller model that reads the stage outputs after each sample
module dsj_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        vld_i,
  input  wire logic        sw1_i,
  input  wire logic        sw2_i,
  input  wire logic [15:0] ao_i,
  input  wire logic [15:0] rel_i,
  output logic             cap_o,
  output logic [33:0]      val_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] dly_q;
  // =========================================================
  // pin capture
  // reading three edges after a sample lets every output settle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_q <= 3'h0;
      cap_o <= 1'b0;
      val_o <= '0;
    end else begin
      dly_q <= {dly_q[1:0], vld_i};
      cap_o <= dly_q[2];
      if (dly_q[2]) begin
        val_o <= {sw1_i, sw2_i, ao_i, rel_i};
      end
    end
  end
endmodule

// [tb/dsj_top_tb_top.sv]
// self-checking bench of the displacement output stage
module dsj_top_tb_top;
  import dsj_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, vld = 1'b0, oor = 1'b0;
  logic [15:0] meas = 16'h0000;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sw1, sw2, cap;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] ao, rel, x;
  logic [33:0] cval;
  logic [33:0] sq[$];
  logic [33:0] ex;
  // fields of a controller capture
  localparam logic [33:0] msk_s1 = 34'h2_0000_0000;
  localparam logic [33:0] msk_s2 = 34'h1_0000_0000;
  localparam logic [33:0] msk_ao = 34'h0_ffff_0000;
  localparam logic [33:0] msk_rl = 34'h0_0000_ffff;
  logic [63:0] rq[$];
  logic on;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  // =========================================================
  // clock, device and controller model
  always #4 clk = ~clk;
  dsj_top u_dsj_top (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .MEAS_I(meas),
    .MEAS_VLD_I(vld), .MEAS_OOR_I(oor), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .SWITCH_OUTPUT_ONE_O(sw1),
    .SECOND_OUTPUT_OR_ANALOG_O(sw2), .AO_CODE_O(ao), .MEAS_REL_O(rel));
  dsj_ctrl_model u_dsj_ctrl_model (.clk_i(clk), .nrst_i(nrst),
    .vld_i(vld), .sw1_i(sw1), .sw2_i(sw2), .ao_i(ao), .rel_i(rel),
    .cap_o(cap), .val_o(cval));
  // =========================================================
  // checking and closing
  task automatic chk(input string nm, input logic [33:0] got,
                     input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // outputs seen by the controller against the oldest note
  always @(posedge clk) begin
    if (cap === 1'b1) begin
      if (sq.size() == 0) begin
        error_cnt++;
        $display("[FAIL] outputs expected none seen %h", cval);
      end else begin
        ex = sq.pop_front();
        chk("sw1", cval & msk_s1, ex & msk_s1);
        chk("sw2", cval & msk_s2, ex & msk_s2);
        chk("ao", cval & msk_ao, ex & msk_ao);
        chk("rel", cval & msk_rl, ex & msk_rl);
      end
    end
  end
  // read data against the oldest note, masked to the field
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("rdata", {2'h0, rdata & rq[0][63:32]},
          {2'h0, rq[0][31:0]});
      chk("rresp", {32'h0, rresp}, 34'h0);
      void'(rq.pop_front());
    end
    // write response at its handshake edge
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk("bresp", {32'h0, bresp}, 34'h0);
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      $display("[FAIL] run cycles expected below %0d seen %0d", 8000, cyc);
      wrap_up;
    end
  end
  // =========================================================
  // bus and sample drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back({m, e});
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic samp(input logic [15:0] v, input logic o, input logic s1,
                      input logic s2, input logic [15:0] a,
                      input logic [15:0] r);
    @(posedge clk);
    meas <= v;
    oor <= o;
    vld <= 1'b1;
    sq.push_back({s1, s2, a, r});
    @(posedge clk);
    vld <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // analog-only sample, display value equals the input
  task automatic sa(input logic [15:0] v, input logic o,
                    input logic [15:0] a);
    samp(v, o, 1'b0, 1'b0, a, v);
  endtask
  // =========================================================
  // main sequence
  initial begin
    void'($urandom(32'h39d6));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // reset values, unmapped place, write-only command
    rd(A_CTRL, CTRL_RST, 32'hffffffff);
    rd(A_ALO, {16'h0, ALO_RST}, 32'hffffffff);
    rd(A_AHI, {16'h0, AHI_RST}, 32'hffffffff);
    rd(A_SPAN, {16'h0, SPAN_RST}, 32'hffffffff);
    wr(8'h20, 32'h1234_5678);
    rd(8'h20, 32'h0, 32'hffffffff);
    rd(A_CMD, 32'h0, 32'hffffffff);
    // one point with hysteresis, second output inverted
    wr(A_CTRL, 32'h60);
    wr(8'h40, 32'h64);
    wr(8'h48, 32'h0a);
    samp(16'h0000, 1'b0, 1'b0, 1'b1, 16'h0, 16'h0000);
    on = 1'b0;
    for (int i = 0; i < 30; i++) begin
      x = 16'($urandom_range(85, 105));
      on = on ? (x >= 16'd90) : (x >= 16'd100);
      samp(x, 1'b0, on, !on, 16'h0, x);
    end
    // edge with hold on ch1, tolerance band on the second output
    wr(A_CTRL, 32'h23);
    wr(8'h48, 32'h0);
    wr(8'h50, 32'h28);
    wr(8'h54, 32'h3c);
    wr(8'h58, 32'h1001);
    wr(8'h60, 32'hc8);
    wr(8'h6c, 32'h14);
    samp(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0000);
    samp(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0000);
    samp(16'h0032, 1'b0, 1'b1, 1'b0, 16'h0, 16'h0032);
    samp(16'h00b4, 1'b0, 1'b0, 1'b1, 16'h0, 16'h00b4);
    samp(16'h00b4, 1'b0, 1'b0, 1'b1, 16'h0, 16'h00b4);
    samp(16'h00dd, 1'b0, 1'b1, 1'b0, 16'h0, 16'h00dd);
    samp(16'h00dd, 1'b0, 1'b0, 1'b0, 16'h0, 16'h00dd);
    rd(A_EDGE, 32'h29, 32'hffff);
    samp(16'h00dc, 1'b0, 1'b0, 1'b1, 16'h0, 16'h00dc);
    samp(16'h00b3, 1'b0, 1'b0, 1'b0, 16'h0, 16'h00b3);
    wr(8'h60, 32'h12c);
    samp(16'h0140, 1'b0, 1'b0, 1'b1, 16'h0, 16'h0140);
    // zone on the second output with hysteresis, both far-on
    wr(A_CTRL, 32'h310);
    wr(8'h64, 32'hc8);
    wr(8'h68, 32'h0a);
    samp(16'h00fa, 1'b0, 1'b0, 1'b0, 16'h0, 16'h00fa);
    samp(16'h0136, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0136);
    samp(16'h013c, 1'b0, 1'b0, 1'b1, 16'h0, 16'h013c);
    samp(16'h0131, 1'b0, 1'b0, 1'b1, 16'h0, 16'h0131);
    samp(16'h0032, 1'b0, 1'b1, 1'b1, 16'h0, 16'h0032);
    // analog current and voltage: span refusal, linear map, out of range
    wr(A_CTRL, 32'h47);
    wr(A_AHI, 32'h190);
    rd(A_AHI, {16'h0, AHI_RST}, 32'hffffffff);
    rd(A_STAT, 32'h4, 32'h4);
    wr(A_AHI, 32'h3e8);
    rd(A_STAT, 32'h0, 32'h4);
    sa(16'h01f4, 1'b0, 16'h2ee0);
    sa(16'h0000, 1'b0, I_LO);
    sa(16'h03e8, 1'b0, I_HI);
    sa(16'h03e9, 1'b0, I_OR);
    sa(16'h01f4, 1'b1, I_OR);
    wr(A_CTRL, 32'h57);
    sa(16'h00fa, 1'b0, 16'h09c4);
    sa(16'h01f4, 1'b1, V_OR);
    // reversed direction, then reversed endpoints
    wr(A_CTRL, 32'h1047);
    samp(16'hff06, 1'b0, 1'b0, 1'b0, 16'h1f40, 16'h00fa);
    wr(A_CTRL, 32'h47);
    wr(A_ALO, 32'h7d0);
    wr(A_AHI, 32'h0);
    sa(16'h01f4, 1'b0, 16'h3e80);
    wr(A_AHI, 32'h3e8);
    wr(A_ALO, 32'h0);
    // teach low endpoint from the current value
    sa(16'h012c, 1'b0, 16'h2260);
    wr(A_CMD, 32'h1);
    rd(A_ALO, 32'h12c, 32'hffff);
    wr(A_ALO, 32'h0);
    // teach high: too narrow first, then accepted
    wr(A_CMD, 32'h2);
    rd(A_AHI, 32'h3e8, 32'hffff);
    rd(A_STAT, 32'h4, 32'h4);
    sa(16'h0384, 1'b0, 16'h47e0);
    wr(A_CMD, 32'h2);
    rd(A_AHI, 32'h384, 32'hffff);
    wr(A_AHI, 32'h3e8);
    // offset recentring and release
    sa(16'h0258, 1'b0, 16'h3520);
    wr(A_CMD, 32'h4);
    rd(A_STAT, 32'h18, 32'h18);
    samp(16'h0258, 1'b0, 1'b0, 1'b0, 16'h2ee0, 16'h0000);
    samp(16'h0064, 1'b0, 1'b0, 1'b0, I_LO, 16'hfe0c);
    samp(16'h04b0, 1'b0, 1'b0, 1'b0, I_OR, 16'h0258);
    wr(A_CMD, 32'h8);
    sa(16'h00fa, 1'b0, 16'h1f40);
    rd(A_STAT, 32'h0, 32'h18);
    // clock enable low: the sample is ignored and nothing moves
    ce <= 1'b0;
    samp(16'h0320, 1'b1, 1'b0, 1'b0, 16'h1f40, 16'h00fa);
    ce <= 1'b1;
    rd(A_MREL, 32'hfa, 32'hffff);
    repeat (8) @(posedge clk);
    if (sq.size() != 0 || rq.size() != 0) begin
      error_cnt++;
      $display("[FAIL] pending notes expected 0 seen %0d",
               sq.size() + rq.size());
    end
    wrap_up;
  end
endmodule
